// ===== shared/tct_pkg.sv
// constants shared by the table code translate unit
package tct_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int CHAR_W = 8;
  localparam int ADDR_W = 14;
  localparam int REQ_W = 1 + ADDR_W + CHAR_W;
  localparam int BUF_DEPTH = 2;
  // ---------------------------------------------------------------
  // character bit positions
  // ---------------------------------------------------------------
  localparam int BIT_1 = 0;
  localparam int BIT_2 = 1;
  localparam int BIT_4 = 2;
  localparam int BIT_8 = 3;
  localparam int BIT_A = 4;
  localparam int BIT_B = 5;
  localparam int BIT_C = 6;
  localparam int BIT_WM = 7;
  // ---------------------------------------------------------------
  // operation and modifier codes
  // ---------------------------------------------------------------
  // translate: C-A-2-1-WM
  localparam logic [CHAR_W-1:0] OP_XLAT = 8'hd3;
  // load record: B-4-2-1-WM
  localparam logic [CHAR_W-1:0] OP_LOAD = 8'ha7;
  // modifier 8-4-2
  localparam logic [CHAR_W-1:0] MOD_842 = 8'h0e;
  // group mark: B-A-8-4-2-1, check bit ignored
  localparam logic [5:0] GM_BITS = 6'h3f;
  // ---------------------------------------------------------------
  // decimal address steps
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STEP_ONE = 14'h0001;
  localparam logic [ADDR_W-1:0] STEP_TEN = 14'h000a;
  localparam logic [ADDR_W-1:0] STEP_HUNDRED = 14'h0064;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
  localparam logic [CHAR_W-1:0] CHAR_RESET = 8'h00;
endpackage

// ===== shared/tct_req_if.sv
// storage request channel between sequencer and request buffer
`timescale 1ns/1ps
`default_nettype none
interface tct_req_if;
  logic valid;
  logic ready;
  logic we;
  logic [tct_pkg::ADDR_W-1:0] addr;
  logic [tct_pkg::CHAR_W-1:0] wdata;
  modport src (output valid, output we, output addr, output wdata,
    input ready);
  modport snk (input valid, input we, input addr, input wdata,
    output ready);
endinterface
`default_nettype wire

// ===== rtl/tct_addr_gen.sv
// table address generation from a record character
`timescale 1ns/1ps
`default_nettype none
module tct_addr_gen (
  // character and table base
  input wire logic [tct_pkg::CHAR_W-1:0] chr,
  input wire logic [tct_pkg::ADDR_W-1:0] base,
  input wire logic use_wm,
  // generated address
  output logic [tct_pkg::ADDR_W-1:0] tab_addr
);
  logic [2:0] units;
  logic [2:0] tens;
  logic [tct_pkg::ADDR_W-1:0] hund;

  always_comb begin
    units = {chr[tct_pkg::BIT_4], chr[tct_pkg::BIT_2], chr[tct_pkg::BIT_1]};
    tens = {chr[tct_pkg::BIT_B], chr[tct_pkg::BIT_A], chr[tct_pkg::BIT_8]};
    hund = (use_wm && chr[tct_pkg::BIT_WM]) ? tct_pkg::STEP_HUNDRED
      : tct_pkg::ADDR_RESET;
    // base hundreds kept, low digits formed
    // three-bit digits never reach 8 or 9
    tab_addr = base + hund
      + tct_pkg::ADDR_W'(tens) * tct_pkg::STEP_TEN
      + tct_pkg::ADDR_W'(units);
  end
endmodule
`default_nettype wire

// ===== rtl/tct_req_buf.sv
// shift buffer for storage requests; head entry drives the pins
`timescale 1ns/1ps
`default_nettype none
module tct_req_buf #(
  parameter int WIDTH = tct_pkg::REQ_W,
  parameter int DEPTH = tct_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  tct_req_if.snk in_ch,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int CNT_W = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] ent_reg [DEPTH];
  logic [WIDTH-1:0] ent_next [DEPTH];
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] wr_idx;
  logic valid_reg;
  logic push;
  logic pop;

  assign in_ch.ready = (cnt_reg != CNT_W'(DEPTH));
  assign push = in_ch.valid && in_ch.ready;
  assign pop = valid_reg && out_ready;
  assign wr_idx = pop ? cnt_reg - CNT_W'(1) : cnt_reg;
  assign out_valid = valid_reg;
  assign out_data = ent_reg[0];

  always_comb begin
    cnt_next = cnt_reg + CNT_W'(push) - CNT_W'(pop);
  end

  // ---------------------------------------------------------------
  // entries shift toward the head on each drain
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_comb begin
      ent_next[i] = ent_reg[i];
      if (pop && i + 1 < DEPTH) begin
        ent_next[i] = ent_reg[(i + 1) % DEPTH];
      end
      if (push && wr_idx == CNT_W'(i)) begin
        ent_next[i] = {in_ch.we, in_ch.addr, in_ch.wdata};
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ent_reg[i] <= '0;
      end else begin
        ent_reg[i] <= ent_next[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      valid_reg <= (cnt_next != '0);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tct_top.sv
// translate and load record sequencer on core storage
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - one instruction walks record upward, stops GM-WM
// - load record copies through GM-WM, marks included
// - translate op C-A-2-1-WM, modifier 8-4-2
// - with-mark variant uses 64 or 128 entries
// - generated low digits never 8 or 9
// - mark variant: table character and mark overwrite record
// - mark variant: record word mark joins address forming
// - translate can be interrupted between characters
// - table base address never indexed
// - no-modifier variant uses small table only
// - no-mark variant keeps record word marks
// - table is only read, never written
// - address keeps hundreds, bits form low digits
// - units from 1-2-4, tens from 8-A-B
// - mark variant: word mark adds one to hundreds
// - three storage cycles per translated character, two per load record character
module tct_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // instruction issue
  input wire logic START,
  input wire logic [tct_pkg::CHAR_W-1:0] OP_CHAR,
  input wire logic D_PRESENT,
  input wire logic [tct_pkg::CHAR_W-1:0] D_CHAR,
  input wire logic [tct_pkg::ADDR_W-1:0] A_ADDR,
  input wire logic [tct_pkg::ADDR_W-1:0] A_INDEX,
  input wire logic [tct_pkg::ADDR_W-1:0] B_ADDR,
  input wire logic INT_REQ,
  // core storage
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [tct_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [tct_pkg::CHAR_W-1:0] MEM_WDATA,
  input wire logic MEM_READY,
  input wire logic MEM_RVALID,
  input wire logic [tct_pkg::CHAR_W-1:0] MEM_RDATA,
  // status
  output logic BUSY,
  output logic DONE,
  output logic INTERRUPTED,
  output logic BAD_OP,
  output logic [tct_pkg::ADDR_W-1:0] NEXT_A_ADDR,
  output logic [tct_pkg::ADDR_W-1:0] NEXT_B_ADDR
);
  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_RD_SRC = 7'b0000010,
    ST_WT_SRC = 7'b0000100,
    ST_RD_TAB = 7'b0001000,
    ST_WT_TAB = 7'b0010000,
    ST_WR_SRC = 7'b0100000,
    ST_WR_DST = 7'b1000000
  } tct_state_t;
  tct_state_t state_reg, state_next;
  logic xlat_reg, xlat_next;
  logic with_wm_reg, with_wm_next;
  logic [tct_pkg::ADDR_W-1:0] a_ptr_reg, a_ptr_next;
  logic [tct_pkg::ADDR_W-1:0] b_ptr_reg, b_ptr_next;
  logic [tct_pkg::ADDR_W-1:0] tab_addr_reg, tab_addr_next;
  logic [tct_pkg::CHAR_W-1:0] chr_reg, chr_next;
  logic [tct_pkg::CHAR_W-1:0] tab_reg, tab_next;
  logic done_reg, done_next;
  logic intr_reg, intr_next;
  logic bad_reg, bad_next;
  logic busy_reg, busy_next;
  logic [tct_pkg::ADDR_W-1:0] gen_addr;
  logic [tct_pkg::CHAR_W-1:0] rd_chr;
  logic rd_gmwm;
  logic op_is_xlat;
  logic op_is_load;
  logic mod_ok;
  tct_req_if req ();
  default clocking cb_chk @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  // ---------------------------------------------------------------
  // address generation and request buffer
  // ---------------------------------------------------------------
  tct_addr_gen u_gen (
    .chr(rd_chr),
    .base(b_ptr_reg),
    .use_wm(with_wm_reg),
    .tab_addr(gen_addr)
  );

  // a stalled storage port backs up here before the sequencer waits
  tct_req_buf u_buf (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .in_ch(req),
    .out_valid(MEM_REQ),
    .out_data({MEM_WE, MEM_ADDR, MEM_WDATA}),
    .out_ready(MEM_READY)
  );

  assign rd_chr = MEM_RDATA;
  // group mark compare ignores the check bit
  assign rd_gmwm = rd_chr[tct_pkg::BIT_WM]
    && (rd_chr[5:0] == tct_pkg::GM_BITS);
  assign op_is_xlat = (OP_CHAR == tct_pkg::OP_XLAT);
  assign op_is_load = (OP_CHAR == tct_pkg::OP_LOAD);
  assign mod_ok = D_PRESENT && (D_CHAR == tct_pkg::MOD_842);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    xlat_next = xlat_reg;
    with_wm_next = with_wm_reg;
    a_ptr_next = a_ptr_reg;
    b_ptr_next = b_ptr_reg;
    tab_addr_next = tab_addr_reg;
    chr_next = chr_reg;
    tab_next = tab_reg;
    done_next = 1'b0;
    intr_next = 1'b0;
    bad_next = 1'b0;
    req.valid = 1'b0;
    req.we = 1'b0;
    req.addr = a_ptr_reg;
    req.wdata = tab_reg;
    case (state_reg)
      ST_IDLE: begin
        if (START) begin
          // no modifier means no-mark variant, small table
          // modifier 8-4-2 means mark variant, up to 128 entries
          xlat_next = op_is_xlat;
          with_wm_next = op_is_xlat && mod_ok;
          a_ptr_next = A_ADDR + A_INDEX;
          b_ptr_next = B_ADDR;
          if ((op_is_xlat && (mod_ok || !D_PRESENT))
              || (op_is_load && mod_ok)) begin
            state_next = ST_RD_SRC;
          end else begin
            bad_next = 1'b1;
          end
        end
      end
      ST_RD_SRC: begin
        // first cycle reads the record character
        req.valid = 1'b1;
        if (req.ready) begin
          state_next = ST_WT_SRC;
        end
      end
      ST_WT_SRC: begin
        if (MEM_RVALID) begin
          chr_next = rd_chr;
          tab_addr_next = gen_addr;
          if (!xlat_reg) begin
            state_next = ST_WR_DST;
          end else if (rd_gmwm) begin
            // end here, nothing fetched from the table
            done_next = 1'b1;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_RD_TAB;
          end
        end
      end
      ST_RD_TAB: begin
        // second cycle reads the table entry
        req.valid = 1'b1;
        req.addr = tab_addr_reg;
        if (req.ready) begin
          state_next = ST_WT_TAB;
        end
      end
      ST_WT_TAB: begin
        if (MEM_RVALID) begin
          tab_next = MEM_RDATA;
          state_next = ST_WR_SRC;
        end
      end
      ST_WR_SRC: begin
        // third cycle writes back over the record
        // mark variant: entry with its mark replaces the character
        req.valid = 1'b1;
        req.we = 1'b1;
        // no-mark variant keeps the record's own mark
        req.wdata = with_wm_reg ? tab_reg
          : {chr_reg[tct_pkg::BIT_WM], tab_reg[6:0]};
        if (req.ready) begin
          // step upward to the next position
          a_ptr_next = a_ptr_reg + tct_pkg::STEP_ONE;
          // stop at a character boundary, resumable
          if (INT_REQ) begin
            intr_next = 1'b1;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_RD_SRC;
          end
        end
      end
      ST_WR_DST: begin
        // whole character replaces destination and its mark
        req.valid = 1'b1;
        req.we = 1'b1;
        req.addr = b_ptr_reg;
        req.wdata = chr_reg;
        if (req.ready) begin
          a_ptr_next = a_ptr_reg + tct_pkg::STEP_ONE;
          b_ptr_next = b_ptr_reg + tct_pkg::STEP_ONE;
          // terminating group mark is copied, then stop
          if (chr_reg[tct_pkg::BIT_WM]
              && chr_reg[5:0] == tct_pkg::GM_BITS) begin
            done_next = 1'b1;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_RD_SRC;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    busy_next = (state_next != ST_IDLE);
  end
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
      xlat_reg <= 1'b0;
      with_wm_reg <= 1'b0;
      a_ptr_reg <= tct_pkg::ADDR_RESET;
      b_ptr_reg <= tct_pkg::ADDR_RESET;
      tab_addr_reg <= tct_pkg::ADDR_RESET;
      chr_reg <= tct_pkg::CHAR_RESET;
      tab_reg <= tct_pkg::CHAR_RESET;
      done_reg <= 1'b0;
      intr_reg <= 1'b0;
      bad_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      xlat_reg <= xlat_next;
      with_wm_reg <= with_wm_next;
      a_ptr_reg <= a_ptr_next;
      b_ptr_reg <= b_ptr_next;
      tab_addr_reg <= tab_addr_next;
      chr_reg <= chr_next;
      tab_reg <= tab_next;
      done_reg <= done_next;
      intr_reg <= intr_next;
      bad_reg <= bad_next;
      busy_reg <= busy_next;
    end
  end
  assign BUSY = busy_reg;
  assign DONE = done_reg;
  assign INTERRUPTED = intr_reg;
  assign BAD_OP = bad_reg;
  assign NEXT_A_ADDR = a_ptr_reg;
  assign NEXT_B_ADDR = b_ptr_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_gm_stop;
    (state_reg == ST_WT_SRC && MEM_RVALID && xlat_reg && rd_gmwm)
    |=> (state_reg == ST_IDLE) && DONE ##1 !DONE;
  endproperty
  a_gm_stop: assert property (p_gm_stop)
    else $error("group mark did not end the translate");
  property p_ascend;
    (state_reg == ST_WR_SRC && req.ready)
    |=> a_ptr_reg == $past(a_ptr_reg) + tct_pkg::STEP_ONE;
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("record pointer did not step up by one");
  property p_tab_low;
    (state_reg == ST_RD_TAB)
    |-> ((tab_addr_reg - b_ptr_reg) % tct_pkg::STEP_TEN) < 14'h0008
      && (((tab_addr_reg - b_ptr_reg) / tct_pkg::STEP_TEN)
        % tct_pkg::STEP_TEN) < 14'h0008;
  endproperty
  a_tab_low: assert property (p_tab_low)
    else $error("table address digit reached 8 or 9");
  property p_hund;
    (state_reg == ST_RD_TAB)
    |-> (tab_addr_reg - b_ptr_reg >= tct_pkg::STEP_HUNDRED)
      == (with_wm_reg && chr_reg[tct_pkg::BIT_WM]);
  endproperty
  a_hund: assert property (p_hund)
    else $error("hundreds digit wrong for word mark");
  property p_keep_wm;
    (req.valid && req.we && xlat_reg && !with_wm_reg)
    |-> req.wdata[tct_pkg::BIT_WM] == chr_reg[tct_pkg::BIT_WM];
  endproperty
  a_keep_wm: assert property (p_keep_wm)
    else $error("record word mark changed by no-mark translate");
  property p_no_tab_wr;
    (req.valid && req.we && xlat_reg) |-> req.addr == a_ptr_reg;
  endproperty
  a_no_tab_wr: assert property (p_no_tab_wr)
    else $error("translate wrote outside the record");
  property p_three;
    (state_reg == ST_WT_SRC && MEM_RVALID && xlat_reg && !rd_gmwm)
    |=> state_reg == ST_RD_TAB ##[1:1000] state_reg == ST_WR_SRC;
  endproperty
  a_three: assert property (p_three)
    else $error("character sequence skipped the table read");
  property p_copy;
    (state_reg == ST_WR_DST)
    |-> req.we && req.addr == b_ptr_reg && req.wdata == chr_reg;
  endproperty
  a_copy: assert property (p_copy)
    else $error("load record wrote wrong data or place");
  property p_no_index;
    (state_reg == ST_IDLE && START && op_is_xlat)
    |=> b_ptr_reg == $past(B_ADDR);
  endproperty
  a_no_index: assert property (p_no_index)
    else $error("table base was modified");
  property p_intr;
    (state_reg == ST_WR_SRC && req.ready && INT_REQ)
    |=> INTERRUPTED && !BUSY;
  endproperty
  a_intr: assert property (p_intr)
    else $error("interrupt not taken at character boundary");
endmodule
`default_nettype wire

// ===== dv/tct_mem_model.sv
// core storage model answering the sequencer's storage requests
`timescale 1ns/1ps
`default_nettype none
module tct_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pace select: 1 = stalls and long read latency
  input wire logic slow,
  // request side
  input wire logic req,
  input wire logic we,
  input wire logic [13:0] addr,
  input wire logic [7:0] wdata,
  output logic ready,
  // answer side
  output logic rvalid,
  output logic [7:0] rdata
);
  // -------------------------------------------------------------
  // storage and activity counts
  // -------------------------------------------------------------
  logic [7:0] mem [0:16383];
  int n_rd = 0;
  int n_wr = 0;
  logic pend;
  logic tog;
  logic [2:0] cnt;
  logic [7:0] hold;
  // -------------------------------------------------------------
  // accept and answer
  // -------------------------------------------------------------
  // idle data inverts so a stale value never looks valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 8'h00;
      pend <= 1'b0;
      tog <= 1'b0;
      cnt <= 3'h0;
      hold <= 8'h00;
    end else begin
      tog <= ~tog;
      ready <= slow ? tog : 1'b1;
      rvalid <= 1'b0;
      rdata <= ~rdata;
      if (req && ready) begin
        if (we) begin
          mem[addr] <= wdata;
          n_wr <= n_wr + 1;
        end else begin
          pend <= 1'b1;
          hold <= mem[addr];
          cnt <= slow ? 3'h3 : 3'h0;
          n_rd <= n_rd + 1;
        end
      end
      if (pend) begin
        if (cnt == 3'h0) begin
          rvalid <= 1'b1;
          rdata <= hold;
          pend <= 1'b0;
        end else begin
          cnt <= cnt - 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/test_table_code_translate_unit.sv
// self-checking bench for the translate and load record sequencer
`timescale 1ns/1ps
`default_nettype none
module test_table_code_translate_unit;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic ref_clk = 1'b0, rstn = 1'b0, start = 1'b0, d_pres = 1'b0;
  logic int_req = 1'b0, slow = 1'b0;
  logic [7:0] op = 8'h00, d_char = 8'h00;
  logic [13:0] a_addr = 14'h0, a_idx = 14'h0, b_addr = 14'h0;
  logic mem_req, mem_we, mem_rdy, mem_rv, busy, done, intr, bad;
  logic [13:0] mem_addr, nxt_a, nxt_b, a;
  logic [7:0] mem_wd, mem_rd;
  logic [2:0] st;
  int n_errors = 0, n_tests = 0, cyc = 0, nr, nw;
  localparam logic [7:0] REC [6] = '{8'h00, 8'h3e, 8'h87, 8'h3f,
    8'hc5, 8'h47};
  tct_top tct_top_i (.REF_CLK(ref_clk), .RSTN(rstn), .START(start),
    .OP_CHAR(op), .D_PRESENT(d_pres), .D_CHAR(d_char), .A_ADDR(a_addr),
    .A_INDEX(a_idx), .B_ADDR(b_addr), .INT_REQ(int_req),
    .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wd), .MEM_READY(mem_rdy), .MEM_RVALID(mem_rv),
    .MEM_RDATA(mem_rd), .BUSY(busy), .DONE(done), .INTERRUPTED(intr),
    .BAD_OP(bad), .NEXT_A_ADDR(nxt_a), .NEXT_B_ADDR(nxt_b));
  tct_mem_model tct_mem_model_i (.clk(ref_clk), .rst_n(rstn),
    .slow(slow), .req(mem_req), .we(mem_we), .addr(mem_addr),
    .wdata(mem_wd), .ready(mem_rdy), .rvalid(mem_rv), .rdata(mem_rd));
  always #4 ref_clk = ~ref_clk;
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // table entry: odd parity over the seven data bits, mark from addr
  function automatic logic [7:0] ent(input logic [13:0] x);
    logic [7:0] e;
    e[5:0] = x[5:0] ^ x[11:6];
    e[6] = ~^e[5:0];
    e[7] = x[0];
    return e;
  endfunction
  function automatic logic [7:0] xl(input logic [7:0] c,
    input logic [13:0] b, input logic wm);
    logic [13:0] t;
    logic [7:0] e;
    t = b + 14'(10 * c[5:3]) + 14'(c[2:0]) + ((wm && c[7]) ? 14'h0064
      : 14'h0000);
    e = ent(t);
    return wm ? e : {c[7], e[6:0]};
  endfunction
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put_rec();
    for (int i = 0; i < 6; i++) tct_mem_model_i.mem[900 + i] = REC[i];
    tct_mem_model_i.mem[906] = 8'hbf;
  endtask
  task automatic run(input logic [7:0] o, input logic dp,
    input logic [7:0] d, input logic [13:0] aa, ix, b, input logic ir);
    nr = tct_mem_model_i.n_rd;
    nw = tct_mem_model_i.n_wr;
    @(posedge ref_clk);
    op <= o;
    d_pres <= dp;
    d_char <= d;
    a_addr <= aa;
    a_idx <= ix;
    b_addr <= b;
    int_req <= ir;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    st = 3'b000;
    for (int k = 0; k < 4000 && st == 3'b000; k++) begin
      #1;
      st = {intr, done, bad};
      if (st == 3'b000) @(posedge ref_clk);
    end
    for (int k = 0; k < 100; k++) begin
      @(posedge ref_clk);
      #1;
      if (!mem_req) break;
    end
    nr = tct_mem_model_i.n_rd - nr;
    nw = tct_mem_model_i.n_wr - nw;
    chk(14'(busy), 14'h0);
  endtask
  task automatic xl_chk(input logic [13:0] b, input logic wm);
    for (int i = 0; i < 6; i++)
      chk(14'(tct_mem_model_i.mem[900 + i]), 14'(xl(REC[i], b, wm)));
    chk(14'(tct_mem_model_i.mem[906]), 14'h00bf);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard: the whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    for (int t = 0; t < 16384; t++) tct_mem_model_i.mem[t] = 8'h00;
    // tables on hundreds: double at 600, single at 300
    for (int t = 300; t < 800; t++) tct_mem_model_i.mem[t] = ent(14'(t));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    put_rec();
    // index on the record only, table base 600 must stay unindexed
    run(tct_pkg::OP_XLAT, 1'b1, tct_pkg::MOD_842, 14'd890, 14'd10,
      14'd600, 1'b0);
    chk(14'(st), 14'h2);
    chk(14'(nr), 14'd13);
    chk(14'(nw), 14'd6);
    chk(nxt_b, 14'd600);
    chk(nxt_a, 14'd906);
    xl_chk(14'd600, 1'b1);
    $display("test mark translate done");
    put_rec();
    slow <= 1'b1;
    run(tct_pkg::OP_XLAT, 1'b0, 8'h00, 14'd900, 14'd0, 14'd300, 1'b0);
    chk(14'(st), 14'h2);
    xl_chk(14'd300, 1'b0);
    $display("test plain translate done");
    put_rec();
    slow <= 1'b0;
    run(tct_pkg::OP_XLAT, 1'b1, tct_pkg::MOD_842, 14'd900, 14'd0,
      14'd600, 1'b1);
    chk(14'(st), 14'h4);
    chk(nxt_a, 14'd901);
    chk(14'(tct_mem_model_i.mem[901]), 14'(REC[1]));
    a = nxt_a;
    run(tct_pkg::OP_XLAT, 1'b1, tct_pkg::MOD_842, a, 14'd0, 14'd600,
      1'b0);
    chk(14'(st), 14'h2);
    xl_chk(14'd600, 1'b1);
    $display("test interrupt done");
    put_rec();
    for (int t = 1200; t < 1208; t++) tct_mem_model_i.mem[t] = 8'hff;
    run(tct_pkg::OP_LOAD, 1'b1, tct_pkg::MOD_842, 14'd900, 14'd0,
      14'd1200, 1'b0);
    chk(14'(st), 14'h2);
    chk(14'(nw), 14'd7);
    chk(nxt_b, 14'd1207);
    chk(nxt_a, 14'd907);
    for (int i = 0; i < 7; i++)
      chk(14'(tct_mem_model_i.mem[1200 + i]), 14'(i < 6 ? REC[i]
        : 8'hbf));
    chk(14'(tct_mem_model_i.mem[1207]), 14'h00ff);
    $display("test load record done");
    run(8'h41, 1'b0, 8'h00, 14'd900, 14'd0, 14'd600, 1'b0);
    chk(14'(st), 14'h1);
    run(tct_pkg::OP_XLAT, 1'b1, 8'h01, 14'd900, 14'd0, 14'd600, 1'b0);
    chk(14'(st), 14'h1);
    chk(14'(nr + nw), 14'h0);
    run(tct_pkg::OP_LOAD, 1'b0, 8'h00, 14'd900, 14'd0, 14'd600, 1'b0);
    chk(14'(st), 14'h1);
    $display("test refused codes done");
    for (int t = 300; t < 800; t++)
      chk(14'(tct_mem_model_i.mem[t]), 14'(ent(14'(t))));
    $display("test table intact done");
    wrap_up();
  end
endmodule
`default_nettype wire
